//--- core/alo_pkg.sv
package alo_pkg;

  // =========================================================
  // register map (byte addresses in a 4 KiB window)
  localparam logic [11:0] OFF_INSTR = 12'h000;
  localparam logic [11:0] OFF_STATUS = 12'h004;
  localparam logic [11:0] OFF_ACCA_LO = 12'h008;
  localparam logic [11:0] OFF_ACCA_HI = 12'h00c;
  localparam logic [11:0] OFF_ACCB_LO = 12'h010;
  localparam logic [11:0] OFF_ACCB_HI = 12'h014;
  localparam logic [11:0] OFF_IMPLICIT_WORK_REG_BASE = 12'h040;
  localparam logic [11:0] OFF_DMEM_BASE = 12'h080;

  // =========================================================
  // status fields
  localparam int BIT_C = 0;
  localparam int BIT_DC = 1;
  localparam int BIT_N = 2;
  localparam int BIT_OV = 3;
  localparam int BIT_Z = 4;
  localparam int BIT_OA = 5;
  localparam int BIT_OB = 6;
  localparam int BIT_SA = 7;
  localparam int BIT_SB = 8;
  localparam int BIT_ILL = 15;
  localparam logic [15:0] STATUS_RST = 16'h0000;
  localparam logic [15:0] IMPLICIT_WORK_REG_RST = 16'h0000;
  localparam logic [39:0] ACC_RST = 40'h00_0000_0000;
  localparam logic [23:0] INSTR_RST = 24'h00_0000;

  // =========================================================
  // sizes and fixed register numbers
  localparam int NUM_IMPLICIT_WORK_REG = 16;
  localparam int NUM_DMEM = 16;
  localparam logic [3:0] IMPL_IMPLICIT_WORK_REG = 4'h0;
  localparam logic [3:0] REM_IMPLICIT_WORK_REG = 4'h1;
  localparam logic [3:0] PF_DEST_BASE = 4'h4;
  localparam logic [3:0] W8 = 4'h8;
  localparam logic [3:0] W10 = 4'ha;
  localparam logic [3:0] W12 = 4'hc;

  // =========================================================
  // opcode byte: form in the upper nibble, kind in the low bits
  localparam logic [3:0] FORM_FILE = 4'h1;
  localparam logic [3:0] FORM_LONG = 4'h2;
  localparam logic [3:0] FORM_REGS = 4'h3;
  localparam logic [3:0] FORM_SHORT = 4'h4;
  localparam logic [3:0] FORM_ACC = 4'h5;
  localparam logic [3:0] FORM_MAC = 4'h6;
  localparam logic [3:0] FORM_SQR = 4'h7;
  localparam logic [3:0] FORM_DIV = 4'h8;
  localparam logic [1:0] KIND_ADD = 2'h0;
  localparam logic [1:0] KIND_CARRY_ADD_OP = 2'h1;
  localparam logic [1:0] KIND_AND = 2'h2;

  // =========================================================
  // prefetch mode codes
  localparam logic [3:0] PF_BANK = 4'h7;
  localparam logic [3:0] PF_INDEXED = 4'he;
  localparam logic [3:0] PF_NONE = 4'hf;
  localparam logic [2:0] NUM_PAIRS = 3'h6;

  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

  typedef enum logic {ALO_ADD, ALO_AND} alo_aluop_t;

endpackage

//--- core/alo_alu_if.sv
`timescale 1ns/1ns
interface alo_alu_if;
  alo_pkg::alo_aluop_t op;
  logic [15:0] a;
  logic [15:0] b;
  logic cin;
  logic [15:0] res;
  logic c;
  logic dc;
  logic n;
  logic ov;
  logic z;
  modport alu (input op, input a, input b, input cin, output res, output c, output dc, output n, output ov, output z);
  modport core (output op, output a, output b, output cin, input res, input c, input dc, input n, input ov, input z);
endinterface

//--- core/alo_alu.sv
`timescale 1ns/1ns
module alo_alu (
  // operands and result
  alo_alu_if.alu bus
);

  logic [16:0] sum;
  logic [4:0] low_sum;

  // =========================================================
  // add with optional carry, or bitwise and
  always_comb begin
    sum = {1'b0, bus.a} + {1'b0, bus.b} + {16'h0000, bus.cin};
    low_sum = {1'b0, bus.a[3:0]} + {1'b0, bus.b[3:0]} + {4'h0, bus.cin};
    if (bus.op == alo_pkg::ALO_AND) begin
      bus.res = bus.a & bus.b;
    end else begin
      bus.res = sum[15:0];
    end
    bus.c = sum[16];
    bus.dc = low_sum[4];
    bus.ov = (bus.a[15] == bus.b[15]) && (sum[15] != bus.a[15]);
    bus.n = bus.res[15];
    bus.z = (bus.res == 16'h0000);
  end

endmodule

//--- core/alo_pf_agu.sv
`timescale 1ns/1ns
module alo_pf_agu (
  // mode code from the instruction
  input wire logic [3:0] mode,
  // pointer pair and index register
  input wire logic [15:0] ptr_lo,
  input wire logic [15:0] ptr_hi,
  input wire logic [15:0] ofs,
  // decoded access
  output logic fetch_en,
  output logic ptr_sel,
  output logic ptr_upd,
  output logic [15:0] ea,
  output logic [15:0] ptr_nxt
);

  logic [3:0] k;
  logic [15:0] step;

  // =========================================================
  // codes 0-6 use the low pointer, 7-13 the high one
  always_comb begin
    ptr_sel = (mode >= alo_pkg::PF_BANK);
    k = ptr_sel ? (mode - alo_pkg::PF_BANK) : mode;
    case (k)
      4'h0: step = 16'h0006;
      4'h1: step = 16'h0004;
      4'h2: step = 16'h0002;
      4'h4: step = 16'hfffa;
      4'h5: step = 16'hfffc;
      4'h6: step = 16'hfffe;
      default: step = 16'h0000;
    endcase
    fetch_en = (mode != alo_pkg::PF_NONE);
    ptr_upd = (mode < alo_pkg::PF_INDEXED) && (step != 16'h0000);
    if (mode == alo_pkg::PF_INDEXED) begin
      ptr_sel = 1'b1;
      ea = ptr_hi + ofs;
    end else begin
      ea = ptr_sel ? ptr_hi : ptr_lo;
    end
    ptr_nxt = ea + step;
  end

endmodule

//--- core/alo_core.sv
// The placing of the registers and register access over AXI4-Lite were chosen for this implementation.
`timescale 1ns/1ns
// How it works
// - sixteen working registers, each usable as base, source or destination.
// - file-register forms use register 0 as second operand and optional destination.
// - squaring multiplies one of registers 4 to 7 by itself.
// - multiply takes one of six ordered pairs from registers 4 to 7.
// - x prefetch via register 8 or 9, steps 2/4/6, indexed 9+12, or none.
// - y prefetch via register 10 or 11, same steps, indexed 11+12, or none.
// - x prefetch data lands in a chosen register 4 to 7.
// - y prefetch data lands in its own chosen register 4 to 7.
// - divide reads dividend and divisor registers directly, no address modes.
// - accumulator add sign-extends, shifts, adds; touches only accumulator flags.
// - long literal carry add: literal plus register plus carry back to register.
// - file carry add to register 0: file plus register 0 plus carry.
// - short literal carry add: base plus five-bit literal plus carry into destination.
// - one 24-bit instruction word, upper 8 bits are the opcode.
module alo_core (
  // clock and reset
  input wire logic mclk,
  input wire logic rst,
  // axi4-lite write address
  input wire logic [31:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  // axi4-lite write data
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  // axi4-lite write response
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  // axi4-lite read address
  input wire logic [31:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  // axi4-lite read data
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready
);

  logic [15:0] w_ff [alo_pkg::NUM_IMPLICIT_WORK_REG];
  logic [15:0] dmem_ff [alo_pkg::NUM_DMEM];
  logic [39:0] acc_ff [2];
  logic [15:0] stat_ff;
  logic [23:0] instr_ff;
  logic awready_ff, wready_ff, bvalid_ff, arready_ff, rvalid_ff;
  logic aw_hold_ff, w_hold_ff;
  logic [31:0] awaddr_ff, wdata_ff, rdata_ff;
  logic [3:0] wstrb_ff;
  logic [1:0] bresp_ff, rresp_ff;

  assign s_axi_awready = awready_ff;
  assign s_axi_wready = wready_ff;
  assign s_axi_bvalid = bvalid_ff;
  assign s_axi_bresp = bresp_ff;
  assign s_axi_arready = arready_ff;
  assign s_axi_rvalid = rvalid_ff;
  assign s_axi_rdata = rdata_ff;
  assign s_axi_rresp = rresp_ff;

  function automatic logic mapped(input logic [31:0] a);
    logic [11:0] r;
    r = {a[11:2], 2'h0};
    mapped = (a[31:12] == 20'h00000) && ((r == alo_pkg::OFF_INSTR) || (r == alo_pkg::OFF_STATUS)
      || (r == alo_pkg::OFF_ACCA_LO) || (r == alo_pkg::OFF_ACCA_HI)
      || (r == alo_pkg::OFF_ACCB_LO) || (r == alo_pkg::OFF_ACCB_HI)
      || (r[11:6] == alo_pkg::OFF_IMPLICIT_WORK_REG_BASE[11:6]) || (r[11:6] == alo_pkg::OFF_DMEM_BASE[11:6]));
  endfunction

  function automatic logic [15:0] merge16(input logic [15:0] old, input logic [15:0] nw, input logic [1:0] st);
    merge16 = {st[1] ? nw[15:8] : old[15:8], st[0] ? nw[7:0] : old[7:0]};
  endfunction

  // =========================================================
  // axi4-lite write channel: address and data taken in any order
  logic wr_go;
  logic [11:0] wa;
  logic bad_instr_strb;
  assign wr_go = aw_hold_ff && w_hold_ff && !bvalid_ff;
  assign wa = {awaddr_ff[11:2], 2'h0};
  assign bad_instr_strb = (wa == alo_pkg::OFF_INSTR) && (wstrb_ff[2:0] != 3'h7);

  always_ff @(posedge mclk) begin
    if (rst) begin
      awready_ff <= 1'b0;
      aw_hold_ff <= 1'b0;
      awaddr_ff <= 32'h0000_0000;
    end else if (s_axi_awvalid && awready_ff) begin
      awready_ff <= 1'b0;
      aw_hold_ff <= 1'b1;
      awaddr_ff <= s_axi_awaddr;
    end else if (bvalid_ff && s_axi_bready) begin
      aw_hold_ff <= 1'b0;
    end else if (!aw_hold_ff && !bvalid_ff) begin
      awready_ff <= 1'b1;
    end
  end

  always_ff @(posedge mclk) begin
    if (rst) begin
      wready_ff <= 1'b0;
      w_hold_ff <= 1'b0;
      wdata_ff <= 32'h0000_0000;
      wstrb_ff <= 4'h0;
    end else if (s_axi_wvalid && wready_ff) begin
      wready_ff <= 1'b0;
      w_hold_ff <= 1'b1;
      wdata_ff <= s_axi_wdata;
      wstrb_ff <= s_axi_wstrb;
    end else if (bvalid_ff && s_axi_bready) begin
      w_hold_ff <= 1'b0;
    end else if (!w_hold_ff && !bvalid_ff) begin
      wready_ff <= 1'b1;
    end
  end

  always_ff @(posedge mclk) begin
    if (rst) begin
      bvalid_ff <= 1'b0;
      bresp_ff <= alo_pkg::RESP_OKAY;
    end else if (wr_go) begin
      bvalid_ff <= 1'b1;
      bresp_ff <= (mapped(awaddr_ff) && !bad_instr_strb) ? alo_pkg::RESP_OKAY : alo_pkg::RESP_SLVERR;
    end else if (s_axi_bready) begin
      bvalid_ff <= 1'b0;
    end
  end

  // =========================================================
  // bus writes into registers and data memory
  logic wr_ok, bw_we, bm_we, exec_go;
  logic [3:0] wr_idx;
  assign wr_ok = wr_go && mapped(awaddr_ff) && !bad_instr_strb;
  assign wr_idx = wa[5:2];
  assign bw_we = wr_ok && (wa[11:6] == alo_pkg::OFF_IMPLICIT_WORK_REG_BASE[11:6]);
  assign bm_we = wr_ok && (wa[11:6] == alo_pkg::OFF_DMEM_BASE[11:6]);
  assign exec_go = wr_ok && (wa == alo_pkg::OFF_INSTR);

  // =========================================================
  // instruction decode
  logic [23:0] ins;
  logic [3:0] form;
  logic [1:0] kind;
  assign ins = wdata_ff[23:0];
  assign form = ins[23:20];
  assign kind = ins[17:16];

  alo_alu_if alu_bus ();
  alo_alu u_alu (
    .bus(alu_bus)
  );

  logic xf_en, xp_sel, xp_upd, yf_en, yp_sel, yp_upd;
  logic [15:0] x_ea, x_np, y_ea, y_np;

  alo_pf_agu u_xagu (
    .mode(ins[11:8]),
    .ptr_lo(w_ff[alo_pkg::W8]),
    .ptr_hi(w_ff[alo_pkg::W8 + 4'h1]),
    .ofs(w_ff[alo_pkg::W12]),
    .fetch_en(xf_en),
    .ptr_sel(xp_sel),
    .ptr_upd(xp_upd),
    .ea(x_ea),
    .ptr_nxt(x_np)
  );

  alo_pf_agu u_yagu (
    .mode(ins[7:4]),
    .ptr_lo(w_ff[alo_pkg::W10]),
    .ptr_hi(w_ff[alo_pkg::W10 + 4'h1]),
    .ofs(w_ff[alo_pkg::W12]),
    .fetch_en(yf_en),
    .ptr_sel(yp_sel),
    .ptr_upd(yp_upd),
    .ea(y_ea),
    .ptr_nxt(y_np)
  );

  logic alu_use, keep_cdo, ill, acc_use, acc_sel, dsp, d_we, d_mem, r_we;
  logic [3:0] d_idx, m_idx, n_idx;
  logic [15:0] d_val, r_val;
  logic signed [39:0] addend;
  logic [40:0] acc_sum;
  logic signed [31:0] prod;

  always_comb begin
    alu_bus.op = alo_pkg::ALO_ADD;
    alu_bus.a = 16'h0000;
    alu_bus.b = w_ff[alo_pkg::IMPL_IMPLICIT_WORK_REG];
    alu_bus.cin = (kind == alo_pkg::KIND_CARRY_ADD_OP) && stat_ff[alo_pkg::BIT_C];
    alu_use = 1'b0;
    keep_cdo = (kind == alo_pkg::KIND_AND);
    ill = 1'b0;
    acc_use = 1'b0;
    acc_sel = ins[15];
    dsp = 1'b0;
    d_mem = 1'b0;
    d_idx = ins[3:0];
    r_we = 1'b0;
    r_val = 16'h0000;
    m_idx = alo_pkg::PF_DEST_BASE;
    n_idx = alo_pkg::PF_DEST_BASE;
    addend = 40'sh00_0000_0000;
    prod = 32'sh0000_0000;
    if (kind == alo_pkg::KIND_AND) begin
      alu_bus.op = alo_pkg::ALO_AND;
    end
    case (form)
      alo_pkg::FORM_FILE: begin
        alu_bus.a = dmem_ff[ins[4:1]];
        alu_use = 1'b1;
        d_mem = ins[13];
        d_idx = d_mem ? ins[4:1] : alo_pkg::IMPL_IMPLICIT_WORK_REG;
      end
      alo_pkg::FORM_LONG: begin
        alu_bus.a = w_ff[ins[3:0]];
        alu_bus.b = {6'h00, ins[13:4]};
        alu_use = 1'b1;
      end
      alo_pkg::FORM_REGS: begin
        alu_bus.a = w_ff[ins[11:8]];
        alu_bus.b = w_ff[ins[7:4]];
        alu_use = 1'b1;
      end
      alo_pkg::FORM_SHORT: begin
        alu_bus.a = w_ff[ins[15:12]];
        alu_bus.b = {11'h000, ins[8:4]};
        alu_use = 1'b1;
      end
      alo_pkg::FORM_ACC: begin
        acc_use = 1'b1;
        addend = {{8{w_ff[ins[3:0]][15]}}, w_ff[ins[3:0]], 16'h0000};
        if (ins[14]) begin
          addend = addend <<< (5'h10 - {1'b0, ins[14:11]});
        end else begin
          addend = addend >>> {1'b0, ins[14:11]};
        end
      end
      alo_pkg::FORM_MAC: begin
        ill = (ins[14:12] >= alo_pkg::NUM_PAIRS);
        case (ins[14:12])
          3'h0: begin m_idx = 4'h4; n_idx = 4'h5; end
          3'h1: begin m_idx = 4'h4; n_idx = 4'h6; end
          3'h2: begin m_idx = 4'h4; n_idx = 4'h7; end
          3'h3: begin m_idx = 4'h5; n_idx = 4'h6; end
          3'h4: begin m_idx = 4'h5; n_idx = 4'h7; end
          default: begin m_idx = 4'h6; n_idx = 4'h7; end
        endcase
        acc_use = !ill;
        dsp = !ill;
      end
      alo_pkg::FORM_SQR: begin
        m_idx = alo_pkg::PF_DEST_BASE + {2'h0, ins[13:12]};
        n_idx = m_idx;
        acc_use = 1'b1;
        dsp = 1'b1;
      end
      alo_pkg::FORM_DIV: begin
        d_idx = alo_pkg::IMPL_IMPLICIT_WORK_REG;
        r_we = (w_ff[ins[3:0]] != 16'h0000);
        r_val = w_ff[ins[7:4]] % w_ff[ins[3:0]];
      end
      default: begin
        ill = 1'b1;
      end
    endcase
    if (dsp) begin
      prod = $signed(w_ff[m_idx]) * $signed(w_ff[n_idx]);
      addend = {{8{prod[31]}}, prod};
    end
    if (alu_use && kind == 2'h3) begin
      alu_use = 1'b0;
      ill = 1'b1;
    end
    d_we = alu_use || r_we;
    d_val = r_we ? (w_ff[ins[7:4]] / w_ff[ins[3:0]]) : alu_bus.res;
    acc_sum = {acc_ff[acc_sel][39], acc_ff[acc_sel]} + {addend[39], addend};
  end

  // =========================================================
  // working registers: bus, result, remainder, prefetch, pointers
  logic [15:0] xf_val, yf_val;
  logic [3:0] xd_idx, yd_idx, xp_idx, yp_idx;
  assign xf_val = dmem_ff[x_ea[4:1]];
  assign yf_val = dmem_ff[y_ea[4:1]];
  assign xd_idx = alo_pkg::PF_DEST_BASE + {2'h0, ins[3:2]};
  assign yd_idx = alo_pkg::PF_DEST_BASE + {2'h0, ins[1:0]};
  assign xp_idx = alo_pkg::W8 + {3'h0, xp_sel};
  assign yp_idx = alo_pkg::W10 + {3'h0, yp_sel};

  genvar gi;
  generate
    for (gi = 0; gi < alo_pkg::NUM_IMPLICIT_WORK_REG; gi++) begin : g_implicit_work_reg
      always_ff @(posedge mclk) begin
        if (rst) begin
          w_ff[gi] <= alo_pkg::IMPLICIT_WORK_REG_RST;
        end else if (bw_we && wr_idx == 4'(gi)) begin
          w_ff[gi] <= merge16(w_ff[gi], wdata_ff[15:0], wstrb_ff[1:0]);
        end else if (exec_go && d_we && !d_mem && d_idx == 4'(gi)) begin
          w_ff[gi] <= d_val;
        end else if (exec_go && r_we && alo_pkg::REM_IMPLICIT_WORK_REG == 4'(gi)) begin
          w_ff[gi] <= r_val;
        end else if (exec_go && dsp && xf_en && xd_idx == 4'(gi)) begin
          w_ff[gi] <= xf_val;
        end else if (exec_go && dsp && yf_en && yd_idx == 4'(gi)) begin
          w_ff[gi] <= yf_val;
        end else if (exec_go && dsp && xp_upd && xp_idx == 4'(gi)) begin
          w_ff[gi] <= x_np;
        end else if (exec_go && dsp && yp_upd && yp_idx == 4'(gi)) begin
          w_ff[gi] <= y_np;
        end
      end
    end
    for (gi = 0; gi < alo_pkg::NUM_DMEM; gi++) begin : g_dmem
      always_ff @(posedge mclk) begin
        if (rst) begin
          dmem_ff[gi] <= alo_pkg::IMPLICIT_WORK_REG_RST;
        end else if (bm_we && wr_idx == 4'(gi)) begin
          dmem_ff[gi] <= merge16(dmem_ff[gi], wdata_ff[15:0], wstrb_ff[1:0]);
        end else if (exec_go && d_we && d_mem && d_idx == 4'(gi)) begin
          dmem_ff[gi] <= d_val;
        end
      end
    end
  endgenerate

  // =========================================================
  // accumulators
  always_ff @(posedge mclk) begin
    if (rst) begin
      acc_ff[0] <= alo_pkg::ACC_RST;
      acc_ff[1] <= alo_pkg::ACC_RST;
    end else if (wr_ok && (wa == alo_pkg::OFF_ACCA_LO || wa == alo_pkg::OFF_ACCB_LO)) begin
      acc_ff[wa[4]][31:0] <= wdata_ff;
    end else if (wr_ok && (wa == alo_pkg::OFF_ACCA_HI || wa == alo_pkg::OFF_ACCB_HI)) begin
      acc_ff[wa[4]][39:32] <= wdata_ff[7:0];
    end else if (exec_go && acc_use) begin
      acc_ff[acc_sel] <= acc_sum[39:0];
    end
  end

  // =========================================================
  // status flags; saturation and illegal bits are sticky
  logic oa_nxt, sa_nxt;
  assign oa_nxt = !((&acc_sum[39:31]) || !(|acc_sum[39:31]));
  assign sa_nxt = (acc_sum[40] != acc_sum[39]);

  always_ff @(posedge mclk) begin
    if (rst) begin
      stat_ff <= alo_pkg::STATUS_RST;
    end else if (wr_ok && wa == alo_pkg::OFF_STATUS) begin
      stat_ff <= merge16(stat_ff, wdata_ff[15:0], wstrb_ff[1:0]);
    end else if (exec_go) begin
      if (alu_use) begin
        stat_ff[alo_pkg::BIT_N] <= alu_bus.n;
        stat_ff[alo_pkg::BIT_Z] <= alu_bus.z;
        if (!keep_cdo) begin
          stat_ff[alo_pkg::BIT_C] <= alu_bus.c;
          stat_ff[alo_pkg::BIT_DC] <= alu_bus.dc;
          stat_ff[alo_pkg::BIT_OV] <= alu_bus.ov;
        end
      end
      if (acc_use && !acc_sel) begin
        stat_ff[alo_pkg::BIT_OA] <= oa_nxt;
        stat_ff[alo_pkg::BIT_SA] <= stat_ff[alo_pkg::BIT_SA] | sa_nxt;
      end
      if (acc_use && acc_sel) begin
        stat_ff[alo_pkg::BIT_OB] <= oa_nxt;
        stat_ff[alo_pkg::BIT_SB] <= stat_ff[alo_pkg::BIT_SB] | sa_nxt;
      end
      if (ill) begin
        stat_ff[alo_pkg::BIT_ILL] <= 1'b1;
      end
    end
  end

  always_ff @(posedge mclk) begin
    if (rst) begin
      instr_ff <= alo_pkg::INSTR_RST;
    end else if (exec_go) begin
      instr_ff <= ins;
    end
  end

  // =========================================================
  // axi4-lite read channel
  logic [11:0] ra;
  logic [31:0] rd_mux;
  assign ra = {s_axi_araddr[11:2], 2'h0};

  always_comb begin
    rd_mux = 32'h0000_0000;
    if (ra[11:6] == alo_pkg::OFF_IMPLICIT_WORK_REG_BASE[11:6]) begin
      rd_mux = {16'h0000, w_ff[ra[5:2]]};
    end else if (ra[11:6] == alo_pkg::OFF_DMEM_BASE[11:6]) begin
      rd_mux = {16'h0000, dmem_ff[ra[5:2]]};
    end else begin
      case (ra)
        alo_pkg::OFF_INSTR: rd_mux = {8'h00, instr_ff};
        alo_pkg::OFF_STATUS: rd_mux = {16'h0000, stat_ff};
        alo_pkg::OFF_ACCA_LO: rd_mux = acc_ff[0][31:0];
        alo_pkg::OFF_ACCA_HI: rd_mux = {24'h00_0000, acc_ff[0][39:32]};
        alo_pkg::OFF_ACCB_LO: rd_mux = acc_ff[1][31:0];
        alo_pkg::OFF_ACCB_HI: rd_mux = {24'h00_0000, acc_ff[1][39:32]};
        default: rd_mux = 32'h0000_0000;
      endcase
    end
  end

  always_ff @(posedge mclk) begin
    if (rst) begin
      arready_ff <= 1'b0;
      rvalid_ff <= 1'b0;
      rdata_ff <= 32'h0000_0000;
      rresp_ff <= alo_pkg::RESP_OKAY;
    end else if (s_axi_arvalid && arready_ff) begin
      arready_ff <= 1'b0;
      rvalid_ff <= 1'b1;
      rdata_ff <= mapped(s_axi_araddr) ? rd_mux : 32'h0000_0000;
      rresp_ff <= mapped(s_axi_araddr) ? alo_pkg::RESP_OKAY : alo_pkg::RESP_SLVERR;
    end else if (rvalid_ff && s_axi_rready) begin
      rvalid_ff <= 1'b0;
    end else if (!rvalid_ff) begin
      arready_ff <= 1'b1;
    end
  end

endmodule

//--- testbench/alo_core_assertions.sv
`timescale 1ns/1ns
module alo_chk (
  // clock and reset
  input wire logic mclk,
  input wire logic rst,
  // bus handshakes
  input wire logic s_axi_awvalid,
  input wire logic s_axi_awready,
  input wire logic s_axi_wvalid,
  input wire logic s_axi_wready,
  input wire logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic s_axi_arvalid,
  input wire logic s_axi_arready,
  input wire logic s_axi_rvalid,
  input wire logic s_axi_rready
);
  default clocking cb @(posedge mclk); endclocking
  default disable iff (rst);
  // =====
  // handshake timing
  chk_ar_answer: assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid && !s_axi_arready)
    else $error("read answer not next cycle");
  chk_aw_drop: assert property (s_axi_awvalid && s_axi_awready |=> !s_axi_awready)
    else $error("awready stayed high");
  chk_b_timing: assert property (s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready
    |=> !s_axi_bvalid ##1 s_axi_bvalid) else $error("write answer timing");
  chk_b_drop: assert property (s_axi_bvalid && s_axi_bready |=> !s_axi_bvalid)
    else $error("bvalid stayed high");
  chk_r_drop: assert property (s_axi_rvalid && s_axi_rready |=> !s_axi_rvalid)
    else $error("rvalid stayed high");
  chk_ready_back: assert property (s_axi_bvalid && s_axi_bready |=> ##[1:2] (s_axi_awready && s_axi_wready))
    else $error("write ready not back");
  chk_reset_idle: assert property ($fell(rst) |-> !s_axi_bvalid && !s_axi_rvalid)
    else $error("valid after reset");
  chk_ready_up: assert property ($fell(rst) |=> s_axi_awready && s_axi_arready)
    else $error("ready late after reset");
endmodule

bind alo_core alo_chk chk_u (.mclk, .rst, .s_axi_awvalid, .s_axi_awready, .s_axi_wvalid, .s_axi_wready,
  .s_axi_bvalid, .s_axi_bready, .s_axi_arvalid, .s_axi_arready, .s_axi_rvalid, .s_axi_rready);

//--- testbench/alo_core_tb.sv
`timescale 1ns/1ns
module alo_core_tb;
  logic mclk = 1'b0;
  logic rst = 1'b1;
  logic [31:0] s_axi_awaddr = 32'h0, s_axi_wdata = 32'h0, s_axi_araddr = 32'h0, s_axi_rdata, rv;
  logic [3:0] s_axi_wstrb = 4'hf;
  logic s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_bready = 1'b0, s_axi_arvalid = 1'b0;
  logic s_axi_rready = 1'b0;
  logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
  logic [1:0] s_axi_bresp, s_axi_rresp, lresp;
  int n_fail = 0;
  int total_checks = 0;
  always #2 mclk = ~mclk;
  alo_core dut_u (.mclk, .rst, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready, .s_axi_wdata, .s_axi_wstrb,
    .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready, .s_axi_araddr, .s_axi_arvalid,
    .s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready);
  // =====
  // bus tasks
  task automatic chk(input logic [31:0] s, input logic [31:0] e);
    total_checks++;
    if (s !== e) begin
      n_fail++;
      $display("BAD %0t seen %h expected %h", $time, s, e);
    end
  endtask
  task automatic wr(input logic [11:0] a, input logic [31:0] d, input logic [3:0] s = 4'hf);
    @(posedge mclk);
    s_axi_awaddr <= {20'h0, a};
    s_axi_wdata <= d;
    s_axi_wstrb <= s;
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    s_axi_bready <= 1'b1;
    do begin
      @(posedge mclk);
      if (s_axi_awready) s_axi_awvalid <= 1'b0;
      if (s_axi_wready) s_axi_wvalid <= 1'b0;
    end while (s_axi_bvalid !== 1'b1);
    lresp = s_axi_bresp;
    s_axi_bready <= 1'b0;
  endtask
  task automatic rd(input logic [11:0] a);
    @(posedge mclk);
    s_axi_araddr <= {20'h0, a};
    s_axi_arvalid <= 1'b1;
    s_axi_rready <= 1'b1;
    do begin
      @(posedge mclk);
      if (s_axi_arready) s_axi_arvalid <= 1'b0;
    end while (s_axi_rvalid !== 1'b1);
    rv = s_axi_rdata;
    lresp = s_axi_rresp;
    s_axi_rready <= 1'b0;
  endtask
  task automatic cw(input logic [11:0] a, input logic [31:0] e);
    rd(a);
    chk(rv, e);
  endtask
  // =====
  // scenarios
  task automatic t_add;
    wr(12'h07c, 32'h7fff);
    wr(12'h04c, 32'h1);
    wr(12'h004, 32'h0);
    wr(12'h000, 32'h300f3e);
    cw(12'h078, 32'h8000);
    cw(12'h004, 32'h0e);
  endtask
  task automatic t_carry_add_op;
    wr(12'h054, 32'hffff);
    wr(12'h004, 32'h1);
    wr(12'h000, 32'h213ff5);
    cw(12'h054, 32'h03ff);
    cw(12'h004, 32'h03);
    wr(12'h088, 32'h10);
    wr(12'h040, 32'h20);
    wr(12'h000, 32'h110004);
    cw(12'h040, 32'h31);
    cw(12'h088, 32'h10);
    cw(12'h004, 32'h0);
    wr(12'h05c, 32'h0);
    wr(12'h004, 32'h1);
    wr(12'h000, 32'h4171f8);
    cw(12'h060, 32'h20);
    cw(12'h004, 32'h02);
  endtask
  task automatic t_and;
    wr(12'h048, 32'h8001);
    wr(12'h04c, 32'h8000);
    wr(12'h004, 32'h0b);
    wr(12'h000, 32'h320234);
    cw(12'h050, 32'h8000);
    cw(12'h004, 32'h0f);
    wr(12'h000, 32'h220004);
    cw(12'h050, 32'h0);
    cw(12'h004, 32'h1b);
  endtask
  task automatic t_div;
    wr(12'h058, 32'd100);
    wr(12'h064, 32'd7);
    wr(12'h000, 32'h800069);
    cw(12'h040, 32'd14);
    cw(12'h044, 32'd2);
  endtask
  task automatic t_fetch;
    wr(12'h060, 32'h6);
    wr(12'h06c, 32'h8);
    wr(12'h08c, 32'h1234);
    wr(12'h090, 32'h5678);
    wr(12'h000, 32'h600286);
    cw(12'h054, 32'h1234);
    cw(12'h058, 32'h5678);
    cw(12'h060, 32'h8);
    cw(12'h06c, 32'hc);
  endtask
  task automatic t_mac;
    wr(12'h010, 32'h0);
    wr(12'h014, 32'h0);
    wr(12'h004, 32'h0);
    wr(12'h050, 32'h5);
    wr(12'h054, 32'h3);
    wr(12'h058, 32'hfffe);
    wr(12'h05c, 32'h7);
    wr(12'h064, 32'h2);
    wr(12'h070, 32'h4);
    wr(12'h08c, 32'h4321);
    // square of register 5 into accumulator b
    wr(12'h000, 32'h709ff0);
    cw(12'h010, 32'h9);
    // pair 5 by 6 into accumulator b, x fetch indexed by register 12
    wr(12'h000, 32'h60befc);
    cw(12'h010, 32'h3);
    cw(12'h014, 32'h0);
    cw(12'h05c, 32'h4321);
    cw(12'h064, 32'h2);
    // pair code 6 is not a legal pair
    wr(12'h000, 32'h60eff0);
    cw(12'h004, 32'h8000);
    cw(12'h010, 32'h3);
  endtask
  task automatic t_acc;
    wr(12'h008, 32'h0);
    wr(12'h00c, 32'h0);
    wr(12'h004, 32'h1f);
    wr(12'h04c, 32'h8000);
    wr(12'h000, 32'h500003);
    cw(12'h008, 32'h80000000);
    cw(12'h00c, 32'hff);
    cw(12'h004, 32'h1f);
  endtask
  task automatic t_bad;
    wr(12'h0fc, 32'h1);
    chk({30'h0, lresp}, 32'h2);
    rd(12'h0fc);
    chk(rv, 32'h0);
    chk({30'h0, lresp}, 32'h2);
    wr(12'h078, 32'h1);
    wr(12'h000, 32'h300f3e, 4'h3);
    chk({30'h0, lresp}, 32'h2);
    cw(12'h078, 32'h1);
  endtask
  task automatic give_verdict;
    $display("checks %0d mismatches %0d", total_checks, n_fail);
    if (n_fail == 0 && total_checks > 0) begin
      $display("All checks passed");
    end else begin
      $display("Checks failed");
    end
    $finish;
  endtask
  initial begin
    repeat (5) @(posedge mclk);
    rst <= 1'b0;
    cw(12'h004, 32'h0);
    t_add;
    t_carry_add_op;
    t_and;
    t_div;
    t_fetch;
    t_mac;
    t_acc;
    t_bad;
    give_verdict;
  end
  initial begin
    #40000;
    n_fail++;
    give_verdict;
  end
endmodule
